// *** readout_pkg.sv ***
package readout_pkg;
  // link frame layout
  localparam int FRAME_BITS = 16;
  localparam int TYPE_BIT = 15;
  localparam int OP_MSB = 14;
  localparam int OP_LSB = 11;
  localparam int GRP_MSB = 10;
  localparam int GRP_LSB = 8;
  localparam int POS_MSB = 1;
  localparam int POS_LSB = 0;
  localparam int CTRL_MSB = 9;
  localparam int CTRL_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam logic [3:0] FILL_NIBBLE = 4'h0;
  // command codes
  localparam logic [3:0] READ_GROUP_ONE_CMD = 4'h0;
  localparam logic [3:0] READ_GROUP_TWO_CMD = 4'h1;
  localparam logic [3:0] READ_GROUP_THREE_CMD = 4'h2;
  localparam logic [3:0] READ_GROUP_FOUR_CMD = 4'h3;
  localparam logic [3:0] READ_GROUP_FIVE_CMD = 4'h4;
  localparam logic [3:0] READ_GROUP_SIX_CMD = 4'h5;
  localparam logic [3:0] READ_GROUP_SEVEN_CMD = 4'h6;
  localparam logic [3:0] READ_GROUP_EIGHT_CMD = 4'h7;
  localparam logic [3:0] WRITE_CFG_ONE_CMD = 4'h8;
  localparam logic [3:0] WRITE_CFG_TWO_CMD = 4'h9;
  localparam logic [3:0] WRITE_CFG_THREE_CMD = 4'hA;
  localparam logic [3:0] WRITE_CFG_FOUR_CMD = 4'hB;
  localparam logic [3:0] WRITE_CFG_FIVE_CMD = 4'hC;
  localparam logic [3:0] WRITE_CFG_SIX_CMD = 4'hD;
  localparam logic [3:0] WRITE_CFG_SEVEN_CMD = 4'hE;
  localparam logic [3:0] READ_SINGLE_CMD = 4'hF;
  // upstream slot codes
  localparam logic [3:0] SLOT_0000 = 4'h0;
  localparam logic [3:0] SLOT_0001 = 4'h1;
  localparam logic [3:0] SLOT_0010 = 4'h2;
  localparam logic [3:0] SLOT_0011 = 4'h3;
  localparam logic [3:0] SLOT_0100 = 4'h4;
  localparam logic [3:0] SLOT_0101 = 4'h5;
  localparam logic [3:0] SLOT_0110 = 4'h6;
  localparam logic [3:0] SLOT_0111 = 4'h7;
  localparam logic [3:0] SLOT_1000 = 4'h8;
  localparam logic [3:0] SLOT_1001 = 4'h9;
  localparam logic [3:0] SLOT_1010 = 4'hA;
  localparam logic [3:0] SLOT_1011 = 4'hB;
  localparam logic [3:0] SLOT_1100 = 4'hC;
  localparam logic [3:0] SLOT_1101 = 4'hD;
  localparam logic [3:0] SLOT_1110 = 4'hE;
  localparam logic [3:0] SLOT_1111 = 4'hF;
  // reset values and stepper layout
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ZERO_WORD = 8'h00;
  localparam logic [9:0] STEP_RESET = 10'h000;
  localparam int ALIGN_B_POS = 7;
  localparam int ALIGN_A_POS = 6;
  localparam int STEP_RSV_POS = 5;
  localparam logic [3:0] LAST_BIT = 4'hF;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_GAP = 2'b10
  } tx_state_type;
endpackage

// *** link_receiver.sv ***
`timescale 1ns/10ps
module link_receiver (
  // link side
  input wire logic link_clk,
  input wire logic down_en,
  input wire logic down_data,
  // to core domain
  output logic [readout_pkg::FRAME_BITS-1:0] rx_word,
  output logic rx_toggle
);
  import readout_pkg::*;
  logic [FRAME_BITS-2:0] shift;
  logic [3:0] bit_count;
  // no reset reaches this domain, so the toggle starts from a known level
  logic toggle = 1'b0;

  assign rx_toggle = toggle;

  // the link clock stops between frames, so the frame enable ends each frame
  always_ff @(posedge link_clk) begin
    if (!down_en) begin
      bit_count <= 4'h0;
    end else begin
      shift <= {shift[FRAME_BITS-3:0], down_data};
      bit_count <= bit_count + 4'h1;
    end
  end

  // word stays still until the next full frame, which is far slower than the crossing
  always_ff @(posedge link_clk) begin
    if (down_en && bit_count == LAST_BIT) begin
      rx_word <= {shift, down_data};
      toggle <= ~toggle;
    end
  end
endmodule

// *** upstream_register_readout.sv ***
// Overview of operation
// - The first group read returns config registers one to four in slots 0000b, 0100b, 1000b, 1100b.
// - The second group read returns config registers five to seven, then a zero word in slot 1100b.
// - The third group read returns diagnostic registers one to four in slots 0001b, 0101b, 1001b, 1101b.
// - The fourth group read returns diagnostic registers five to eight in slots 0010b, 0110b, 1010b, 1110b.
// - The fifth group read returns diagnostic nine to eleven and the chip identifier in slot 1111b.
// - The sixth group read returns watchdog query, a zero word, and stepper count high and low.
// - The seventh group read returns diagnostic twelve twice, watchdog response and response time.
// - The eighth group read returns response time, request low and high bytes and the stage counter.
// - A 10-bit step count is kept, bits 4:0 in the low register and bits 9:5 in the high register.
// - Both stepper registers carry two alignment bits at 7 and 6 that match when sampled together.
// - Bit 5 of both stepper registers reads zero and both registers are read-only.
// - A single read sends one 16-bit upstream frame whose top nibble is the slot code.
`timescale 1ns/10ps
module upstream_register_readout #(
  parameter logic [7:0] CHIP_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // downstream link
  input wire logic link_clk,
  input wire logic down_en,
  input wire logic down_data,
  // upstream link
  output logic up_frame,
  output logic up_data,
  // configuration registers
  output logic [7:0] config_one,
  output logic [7:0] config_two,
  output logic [7:0] config_three,
  output logic [7:0] config_four,
  output logic [7:0] config_five,
  output logic [7:0] config_six,
  output logic [7:0] config_seven,
  // output control registers
  output logic [7:0] output_control_one,
  output logic [7:0] output_control_two,
  output logic [7:0] output_control_three,
  output logic [7:0] output_control_four,
  // diagnostic sources
  input wire logic [7:0] diag_one,
  input wire logic [7:0] diag_two,
  input wire logic [7:0] diag_three,
  input wire logic [7:0] diag_four,
  input wire logic [7:0] diag_five,
  input wire logic [7:0] diag_six,
  input wire logic [7:0] diag_seven,
  input wire logic [7:0] diag_eight,
  input wire logic [7:0] diag_nine,
  input wire logic [7:0] diag_ten,
  input wire logic [7:0] diag_eleven,
  input wire logic [7:0] diag_twelve,
  // watchdog sources
  input wire logic [7:0] watchdog_query,
  input wire logic [7:0] watchdog_response,
  input wire logic [7:0] response_time,
  input wire logic [7:0] watchdog_request_low,
  input wire logic [7:0] watchdog_request_high,
  input wire logic [7:0] watchdog_stage_counter,
  // stepper
  input wire logic step_pulse,
  input wire logic step_up
);
  import readout_pkg::*;

  logic [FRAME_BITS-1:0] rx_word;
  logic rx_toggle;
  logic rx_meta;
  logic rx_sync;
  logic rx_seen;
  logic new_frame;
  logic is_cmd;
  logic [3:0] op;
  logic [7:0] payload;
  logic read_group;
  logic read_single;
  logic accept_read;
  logic [9:0] stepper_step_count;
  logic count_align_bit_a;
  logic count_align_bit_b;
  logic [7:0] stepper_count_high;
  logic [7:0] stepper_count_low;
  logic [FRAME_BITS-1:0] grp [8][4];
  tx_state_type tx_state;
  logic [4*FRAME_BITS-1:0] tx_buf;
  logic [2:0] tx_words;
  logic [3:0] tx_bit;

  function automatic logic [FRAME_BITS-1:0] mk(input logic [3:0] slot, input logic [7:0] data);
    mk = {slot, FILL_NIBBLE, data};
  endfunction

  link_receiver rx (
    .link_clk(link_clk),
    .down_en(down_en),
    .down_data(down_data),
    .rx_word(rx_word),
    .rx_toggle(rx_toggle)
  );

  // frame event crosses by toggle; the word is stable long before the toggle lands
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_seen <= 1'b0;
    end else begin
      rx_meta <= rx_toggle;
      rx_sync <= rx_meta;
      rx_seen <= rx_sync;
    end
  end

  assign new_frame = rx_sync ^ rx_seen;
  assign is_cmd = rx_word[TYPE_BIT];
  assign op = rx_word[OP_MSB:OP_LSB];
  assign payload = rx_word[DATA_MSB:DATA_LSB];
  assign read_group = new_frame && is_cmd && !op[3];
  assign read_single = new_frame && is_cmd && op == READ_SINGLE_CMD;
  // reads arriving while a reply is still going out are dropped
  assign accept_read = (read_group || read_single) && tx_state == TX_IDLE;

  // each config register only moves on its own write command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_one <= CFG_RESET;
      config_two <= CFG_RESET;
      config_three <= CFG_RESET;
      config_four <= CFG_RESET;
      config_five <= CFG_RESET;
      config_six <= CFG_RESET;
      config_seven <= CFG_RESET;
    end else if (new_frame && is_cmd) begin
      case (op)
        WRITE_CFG_ONE_CMD: config_one <= payload;
        WRITE_CFG_TWO_CMD: config_two <= payload;
        WRITE_CFG_THREE_CMD: config_three <= payload;
        WRITE_CFG_FOUR_CMD: config_four <= payload;
        WRITE_CFG_FIVE_CMD: config_five <= payload;
        WRITE_CFG_SIX_CMD: config_six <= payload;
        WRITE_CFG_SEVEN_CMD: config_seven <= payload;
        default: ;
      endcase
    end
  end

  // data frames steer the drivers and have no readback path
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      output_control_one <= CTRL_RESET;
      output_control_two <= CTRL_RESET;
      output_control_three <= CTRL_RESET;
      output_control_four <= CTRL_RESET;
    end else if (new_frame && !is_cmd) begin
      case (rx_word[CTRL_MSB:CTRL_LSB])
        2'h0: output_control_one <= payload;
        2'h1: output_control_two <= payload;
        2'h2: output_control_three <= payload;
        2'h3: output_control_four <= payload;
        default: ;
      endcase
    end
  end

  // alignment pair advances with every count change so a torn read shows up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stepper_step_count <= STEP_RESET;
      count_align_bit_a <= 1'b0;
      count_align_bit_b <= 1'b0;
    end else if (step_pulse) begin
      if (step_up) begin
        stepper_step_count <= stepper_step_count + 10'h001;
      end else begin
        stepper_step_count <= stepper_step_count - 10'h001;
      end
      {count_align_bit_b, count_align_bit_a} <= {count_align_bit_b, count_align_bit_a} + 2'h1;
    end
  end

  always_comb begin
    stepper_count_high = 8'h00;
    stepper_count_high[ALIGN_B_POS] = count_align_bit_b;
    stepper_count_high[ALIGN_A_POS] = count_align_bit_a;
    stepper_count_high[STEP_RSV_POS] = 1'b0;
    stepper_count_high[4:0] = stepper_step_count[9:5];
    stepper_count_low = 8'h00;
    stepper_count_low[ALIGN_B_POS] = count_align_bit_b;
    stepper_count_low[ALIGN_A_POS] = count_align_bit_a;
    stepper_count_low[STEP_RSV_POS] = 1'b0;
    stepper_count_low[4:0] = stepper_step_count[4:0];
  end

  // reply table: group, then position in send order
  always_comb begin
    grp[0][0] = mk(SLOT_0000, config_one);
    grp[0][1] = mk(SLOT_0100, config_two);
    grp[0][2] = mk(SLOT_1000, config_three);
    grp[0][3] = mk(SLOT_1100, config_four);
    grp[1][0] = mk(SLOT_0000, config_five);
    grp[1][1] = mk(SLOT_0100, config_six);
    grp[1][2] = mk(SLOT_1000, config_seven);
    grp[1][3] = mk(SLOT_1100, ZERO_WORD);
    grp[2][0] = mk(SLOT_0001, diag_one);
    grp[2][1] = mk(SLOT_0101, diag_two);
    grp[2][2] = mk(SLOT_1001, diag_three);
    grp[2][3] = mk(SLOT_1101, diag_four);
    grp[3][0] = mk(SLOT_0010, diag_five);
    grp[3][1] = mk(SLOT_0110, diag_six);
    grp[3][2] = mk(SLOT_1010, diag_seven);
    grp[3][3] = mk(SLOT_1110, diag_eight);
    grp[4][0] = mk(SLOT_0011, diag_nine);
    grp[4][1] = mk(SLOT_0111, diag_ten);
    grp[4][2] = mk(SLOT_1011, diag_eleven);
    grp[4][3] = mk(SLOT_1111, CHIP_ID);
    grp[5][0] = mk(SLOT_0000, watchdog_query);
    grp[5][1] = mk(SLOT_0100, ZERO_WORD);
    grp[5][2] = mk(SLOT_1000, stepper_count_high);
    grp[5][3] = mk(SLOT_1100, stepper_count_low);
    grp[6][0] = mk(SLOT_0000, diag_twelve);
    grp[6][1] = mk(SLOT_0100, diag_twelve);
    grp[6][2] = mk(SLOT_1000, watchdog_response);
    grp[6][3] = mk(SLOT_1100, response_time);
    grp[7][0] = mk(SLOT_0001, response_time);
    grp[7][1] = mk(SLOT_0101, watchdog_request_low);
    grp[7][2] = mk(SLOT_1001, watchdog_request_high);
    grp[7][3] = mk(SLOT_1101, watchdog_stage_counter);
  end

  // whole group is snapshot at once, so both stepper halves come from one count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_buf <= '0;
      tx_words <= 3'h0;
      tx_bit <= 4'h0;
      up_frame <= 1'b0;
      up_data <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          up_frame <= 1'b0;
          up_data <= 1'b0;
          tx_bit <= 4'h0;
          if (accept_read && read_single) begin
            tx_buf <= {grp[rx_word[GRP_MSB:GRP_LSB]][rx_word[POS_MSB:POS_LSB]], 48'h0};
            tx_words <= 3'h1;
            tx_state <= TX_SHIFT;
          end else if (accept_read) begin
            tx_buf <= {grp[op[2:0]][0], grp[op[2:0]][1], grp[op[2:0]][2], grp[op[2:0]][3]};
            tx_words <= 3'h4;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          up_frame <= 1'b1;
          up_data <= tx_buf[4*FRAME_BITS-1];
          tx_buf <= {tx_buf[4*FRAME_BITS-2:0], 1'b0};
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == LAST_BIT) begin
            tx_words <= tx_words - 3'h1;
            tx_state <= TX_GAP;
          end
        end
        TX_GAP: begin
          up_frame <= 1'b0;
          up_data <= 1'b0;
          tx_bit <= 4'h0;
          tx_state <= (tx_words == 3'h0) ? TX_IDLE : TX_SHIFT;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // checks
  sequence group_read_seq(logic [3:0] code);
    accept_read && read_group && op == code;
  endsequence

  property write_lands(logic [3:0] code, logic [7:0] target);
    @(posedge core_clk) disable iff (!rst_n)
      (new_frame && is_cmd && op == code) |=> target == $past(payload);
  endproperty

  AST_CFG_ONE_WRITE: assert property (write_lands(WRITE_CFG_ONE_CMD, config_one))
    else $error("config one not loaded by its write");
  AST_CFG_SEVEN_WRITE: assert property (write_lands(WRITE_CFG_SEVEN_CMD, config_seven))
    else $error("config seven not loaded by its write");
  AST_CFG_ONE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(new_frame && is_cmd && op == WRITE_CFG_ONE_CMD) |=> $stable(config_one))
    else $error("config one changed without its write");
  AST_GROUP_TWO_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_TWO_CMD) |=> tx_buf[15:0] == {SLOT_1100, FILL_NIBBLE, ZERO_WORD})
    else $error("group two last word not zero");
  AST_GROUP_THREE_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_THREE_CMD) |=> tx_buf[63:48] == {SLOT_0001, FILL_NIBBLE, $past(diag_one)})
    else $error("group three first word wrong");
  AST_GROUP_FOUR_LAST: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_FOUR_CMD) |=> tx_buf[15:0] == {SLOT_1110, FILL_NIBBLE, $past(diag_eight)})
    else $error("group four last word wrong");
  AST_GROUP_FIVE_IDENT: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_FIVE_CMD) |=> tx_buf[15:0] == {SLOT_1111, FILL_NIBBLE, CHIP_ID})
    else $error("identifier not in slot 1111b");
  AST_STEP_PAIR_ALIGNED: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_SIX_CMD) |=> tx_buf[23:22] == tx_buf[7:6] && tx_buf[31:28] == SLOT_1000)
    else $error("stepper halves misaligned in group six");
  AST_GROUP_SEVEN_DUP: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_SEVEN_CMD) |=> tx_buf[55:48] == tx_buf[39:32])
    else $error("diag twelve not repeated");
  AST_GROUP_EIGHT_COUNTER: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_EIGHT_CMD) |=> tx_buf[15:12] == SLOT_1101
      && tx_buf[7:0] == $past(watchdog_stage_counter))
    else $error("stage counter word wrong");
  AST_STEP_COUNT_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
      step_pulse && step_up |=> stepper_step_count == $past(stepper_step_count) + 10'h001)
    else $error("step count did not advance");
  AST_ALIGN_MOVES: assert property (@(posedge core_clk) disable iff (!rst_n)
      !step_pulse |=> $stable({count_align_bit_b, count_align_bit_a}))
    else $error("alignment bits moved without a step");
  AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_SIX_CMD) |=> !tx_buf[16 + STEP_RSV_POS] && !tx_buf[STEP_RSV_POS])
    else $error("reserved stepper bit set");
  AST_FRAME_LENGTH: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(up_frame) |-> ##15 up_frame ##1 !up_frame)
    else $error("upstream frame not 16 bits");
  AST_SINGLE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept_read && read_single |-> ##2 $rose(up_frame) ##16 !up_frame && tx_state == TX_IDLE)
    else $error("single read did not send exactly one frame");
  AST_CTRL_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      new_frame && !is_cmd && rx_word[CTRL_MSB:CTRL_LSB] == 2'h2 |=> output_control_three == $past(payload))
    else $error("control register three not loaded");
  AST_GROUP_ONE_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_ONE_CMD) |=> tx_buf[63:48] == {SLOT_0000, FILL_NIBBLE, $past(config_one)}
      && tx_buf[15:0] == {SLOT_1100, FILL_NIBBLE, $past(config_four)})
    else $error("group one words out of place");
  AST_GROUP_SIX_QUERY: assert property (@(posedge core_clk) disable iff (!rst_n)
      group_read_seq(READ_GROUP_SIX_CMD) |=> tx_buf[63:48] == {SLOT_0000, FILL_NIBBLE, $past(watchdog_query)}
      && tx_buf[47:32] == {SLOT_0100, FILL_NIBBLE, ZERO_WORD})
    else $error("group six query or unused word wrong");
endmodule

// *** link_master.sv ***
`timescale 1ns/10ps
module link_master (
  // clocks
  input wire logic core_clk,
  output logic link_clk,
  // downstream
  output logic down_en,
  output logic down_data,
  // upstream
  input wire logic up_frame,
  input wire logic up_data
);
  initial begin
    link_clk = 1'b0;
    down_en = 1'b0;
    down_data = 1'b0;
    // one idle edge clears the receiver before the first frame
    #50 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  end

  // link clock runs while bits are shifted, then for one idle edge after down_en drops; n below 16 aborts mid-word
  task automatic send_bits(input logic [15:0] w, input int n);
    down_en = 1'b1;
    for (int i = 15; i > 15 - n; i--) begin
      down_data = w[i];
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
    down_en = 1'b0;
    // released line shows the inverse so a stale bit cannot pass for data
    down_data = ~down_data;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
    #40;
  endtask

  task automatic get_word(output logic [15:0] w, output logic ok);
    ok = 1'b0;
    w = 16'h0000;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge core_clk);
      ok = (up_frame === 1'b1);
    end
    for (int i = 15; i >= 0 && ok; i--) begin
      if (i < 15) @(negedge core_clk);
      w[i] = up_data;
    end
  endtask
endmodule

// *** upstream_register_readout_bench.sv ***
`timescale 1ns/10ps
module upstream_register_readout_bench;
  import readout_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary value
  localparam logic [1:0] SLOT_LOW [0:7] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd3, 2'd0, 2'd0, 2'd1};
  logic core_clk;
  logic rst_n;
  logic link_clk;
  logic down_en;
  logic down_data;
  logic up_frame;
  logic up_data;
  logic step_pulse;
  logic step_up;
  logic [7:0] cfg [0:6];
  logic [7:0] ctl [0:3];
  logic [7:0] src [0:17];
  logic [7:0] exp_cfg [0:6];
  logic [9:0] step_exp;
  logic [1:0] align_exp;
  int num_errors;
  int checks_done;

  upstream_register_readout #(.CHIP_ID(ID_VAL)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .down_en(down_en), .down_data(down_data),
    .up_frame(up_frame), .up_data(up_data), .config_one(cfg[0]), .config_two(cfg[1]), .config_three(cfg[2]),
    .config_four(cfg[3]), .config_five(cfg[4]), .config_six(cfg[5]), .config_seven(cfg[6]),
    .output_control_one(ctl[0]), .output_control_two(ctl[1]), .output_control_three(ctl[2]),
    .output_control_four(ctl[3]), .diag_one(src[0]), .diag_two(src[1]), .diag_three(src[2]), .diag_four(src[3]),
    .diag_five(src[4]), .diag_six(src[5]), .diag_seven(src[6]), .diag_eight(src[7]), .diag_nine(src[8]),
    .diag_ten(src[9]), .diag_eleven(src[10]), .diag_twelve(src[11]), .watchdog_query(src[12]),
    .watchdog_response(src[13]), .response_time(src[14]), .watchdog_request_low(src[15]),
    .watchdog_request_high(src[16]), .watchdog_stage_counter(src[17]), .step_pulse(step_pulse), .step_up(step_up)
  );

  link_master mdl (
    .core_clk(core_clk), .link_clk(link_clk), .down_en(down_en), .down_data(down_data),
    .up_frame(up_frame), .up_data(up_data)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole sequence needs well under 100 us
  initial begin
    #500000;
    num_errors++;
    final_report();
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  function automatic logic [15:0] exp_word(input int g, input int k);
    logic [7:0] d;
    case (g)
      0: d = exp_cfg[k];
      1: d = (k == 3) ? ZERO_WORD : exp_cfg[4 + k];
      2, 3: d = src[(g - 2) * 4 + k];
      4: d = (k == 3) ? ID_VAL : src[8 + k];
      5: d = (k == 0) ? src[12] : (k == 1) ? ZERO_WORD : {align_exp, 1'b0, (k == 2) ? step_exp[9:5] : step_exp[4:0]};
      6: d = (k < 2) ? src[11] : src[11 + k];
      default: d = src[14 + k];
    endcase
    return {2'(k), SLOT_LOW[g], FILL_NIBBLE, d};
  endfunction

  // idle upstream keeps both lines low
  task automatic t_quiet(input int n);
    repeat (n) begin
      @(negedge core_clk);
      cmp8({6'h00, up_frame, up_data}, 8'h00);
    end
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 7; i++) cmp8(cfg[i], CFG_RESET);
    for (int i = 0; i < 4; i++) cmp8(ctl[i], CTRL_RESET);
    t_quiet(4);
  endtask

  task automatic t_write;
    mdl.send_bits({1'b1, WRITE_CFG_ONE_CMD, 3'b000, 8'hEE}, 9);
    for (int i = 0; i < 7; i++) begin
      exp_cfg[i] = 8'h50 + 8'(i);
      mdl.send_bits({1'b1, WRITE_CFG_ONE_CMD + 4'(i), 3'b000, exp_cfg[i]}, 16);
    end
    for (int j = 0; j < 4; j++) mdl.send_bits({1'b0, 5'h00, 2'(j), 8'h90 + 8'(j)}, 16);
    wait_clk(8);
    for (int i = 0; i < 7; i++) cmp8(cfg[i], exp_cfg[i]);
    for (int j = 0; j < 4; j++) cmp8(ctl[j], 8'h90 + 8'(j));
  endtask

  // a stepper read whose halves disagree is repeated
  task automatic t_group(input int g);
    logic [15:0] w [0:3];
    logic ok;
    int tries;
    tries = 0;
    do begin
      mdl.send_bits({1'b1, 4'(g), 11'h000}, 16);
      for (int k = 0; k < 4; k++) mdl.get_word(w[k], ok);
      tries++;
    end while (g == 5 && w[2][7:6] !== w[3][7:6] && tries < 3);
    for (int k = 0; k < 4; k++) cmp16(w[k], exp_word(g, k));
    wait_clk(4);
  endtask

  task automatic t_step(input logic up, input int n);
    for (int i = 0; i < n; i++) begin
      step_up <= up;
      step_pulse <= 1'b1;
      @(posedge core_clk);
      step_pulse <= 1'b0;
      @(posedge core_clk);
      step_exp = up ? step_exp + 10'd1 : step_exp - 10'd1;
      align_exp = align_exp + 2'd1;
    end
    wait_clk(2);
  endtask

  task automatic t_single;
    logic [15:0] w;
    logic ok;
    mdl.send_bits({1'b1, READ_SINGLE_CMD, 3'd4, 6'h00, 2'd3}, 16);
    mdl.get_word(w, ok);
    cmp16(w, exp_word(4, 3));
    t_quiet(40);
  endtask

  // second read lands while the first reply is running and is dropped
  task automatic t_busy;
    logic [15:0] w;
    logic ok;
    fork
      begin
        mdl.send_bits({1'b1, READ_GROUP_THREE_CMD, 11'h000}, 16);
        mdl.send_bits({1'b1, READ_GROUP_FOUR_CMD, 11'h000}, 16);
      end
      for (int k = 0; k < 4; k++) begin
        mdl.get_word(w, ok);
        cmp16(w, exp_word(2, k));
      end
    join
    t_quiet(60);
  endtask

  initial begin
    rst_n = 1'b0;
    step_pulse = 1'b0;
    step_up = 1'b1;
    step_exp = STEP_RESET;
    align_exp = 2'd0;
    num_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 18; i++) src[i] = 8'hA0 + 8'(i);
    for (int i = 0; i < 7; i++) exp_cfg[i] = CFG_RESET;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_clk(2);
    t_reset();
    t_group(5);
    t_write();
    t_group(0);
    t_group(1);
    t_group(2);
    t_group(3);
    t_group(4);
    t_group(6);
    t_group(7);
    t_step(1'b1, 37);
    t_group(5);
    t_step(1'b0, 40);
    t_group(5);
    t_single();
    for (int i = 0; i < 18; i++) src[i] <= 8'h60 - 8'(i);
    wait_clk(1);
    t_busy();
    final_report();
  end
endmodule
